// ---- frac_ctrl.v ----
// fractional-delay control for four PWM submodules behind AXI4-Lite
// assumes all PWM-side inputs come from logic on CLK_SYS and that
// the bus master keeps one write and one read outstanding at most
//
// What this block does
// - four fraction_control registers, index 10h plus 48 decimal words per submodule
// - bit 15 is a read-only test status bit, writes ignored
// - test status bit resets to zero, may read either value later
// - bits 14..9 and 7..5 are read-only and always zero
// - bit 8 powers up fractional delay on 1, turns it off on 0
// - shared delay block usable 25 us after the first power-up bit
// - shared block powers down only when all four power-up bits are zero
// - with fractional logic off, the submodule uses whole-cycle edges only
// - analog state clearing works even with PWM outputs disabled
// - bit 4 enables fractional placement for the second output
// - enabled: rise/fall fractions applied to second output; else bypassed
// - bit 4 double-buffered, loads at load cycle or immediately; locked while load_okay
`timescale 1ns/1ps
`include "frac_ctrl_regs.vh"
`default_nettype none

module frac_ctrl (
  // clock and reset
  input wire CLK_SYS,
  input wire RST_N,
  // axi4-lite write address
  input wire [11:0] S_AXI_AWADDR,
  input wire S_AXI_AWVALID,
  output reg S_AXI_AWREADY,
  // axi4-lite write data
  input wire [31:0] S_AXI_WDATA,
  input wire [3:0] S_AXI_WSTRB,
  input wire S_AXI_WVALID,
  output reg S_AXI_WREADY,
  // axi4-lite write response
  output reg [1:0] S_AXI_BRESP,
  output reg S_AXI_BVALID,
  input wire S_AXI_BREADY,
  // axi4-lite read address
  input wire [11:0] S_AXI_ARADDR,
  input wire S_AXI_ARVALID,
  output reg S_AXI_ARREADY,
  // axi4-lite read data
  output reg [31:0] S_AXI_RDATA,
  output reg [1:0] S_AXI_RRESP,
  output reg S_AXI_RVALID,
  input wire S_AXI_RREADY,
  // pwm counter events, one bit per submodule
  input wire [3:0] LOAD_CYCLE,
  input wire [3:0] PERIOD_END,
  input wire [3:0] DUTY_NONZERO,
  // second output fractions from the value registers, 5 bits per submodule
  input wire [19:0] RISE_FRAC_IN,
  input wire [19:0] FALL_FRAC_IN,
  // to the analog delay block and the edge generators
  output reg DELAY_POWER,
  output reg DELAY_READY,
  output reg [3:0] LOAD_OKAY,
  output reg [3:0] FRAC_ACTIVE,
  output reg [19:0] RISE_FRAC_OUT,
  output reg [19:0] FALL_FRAC_OUT
);

  // warm-up length, rounded up to whole cycles
  localparam integer WARM_INT = (`WARM_UP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam [8:0] WARM_CYC = WARM_INT[8:0];

  //////////////////////////////////////////////////////////////////////////////
  // write channel capture

  reg [11:0] wa_q;
  reg [15:0] wd_q;
  reg [1:0] ws_q;
  reg wexec_q;
  wire wr_go;

  // both halves taken and no answer pending: perform the write once
  assign wr_go = !S_AXI_AWREADY && !S_AXI_WREADY && !S_AXI_BVALID && !wexec_q;

  // address and data are taken independently, in either order
  always @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      S_AXI_AWREADY <= 1'b1;
      S_AXI_WREADY <= 1'b1;
      wa_q <= 12'h000;
      wd_q <= 16'h0000;
      ws_q <= 2'h0;
      wexec_q <= 1'b0;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        wa_q <= S_AXI_AWADDR;
        S_AXI_AWREADY <= 1'b0;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        wd_q <= S_AXI_WDATA[15:0];
        ws_q <= S_AXI_WSTRB[1:0];
        S_AXI_WREADY <= 1'b0;
      end
      wexec_q <= wr_go;
      // reopen both channels only when the response is taken
      if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_AWREADY <= 1'b1;
        S_AXI_WREADY <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // address decode

  wire [3:0] wr_hit;
  wire [3:0] rd_hit;
  wire ld_wr;
  wire wr_mapped;
  wire [3:0] ar_lane;

  assign ld_wr = wr_go && (wa_q == `LDCTL_ADDR);
  assign wr_mapped = (|wr_hit) || (wa_q == `LDCTL_ADDR) || (wa_q == `STAT_ADDR);

  // write response: unmapped addresses answer slave error
  always @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= `RESP_OKAY;
    end else if (wr_go) begin
      S_AXI_BVALID <= 1'b1;
      S_AXI_BRESP <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
    end else if (S_AXI_BREADY) begin
      S_AXI_BVALID <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // shared analog delay block power and warm-up

  reg [3:0] pu_q;
  reg [3:0] imm_q;
  reg [3:0] clr_q;
  reg [3:0] act_q;
  reg [3:0] buf_q;
  reg [8:0] warm_q;
  wire any_pu;

  // any one submodule holding its bit keeps the block up
  assign any_pu = |pu_q;

  // warm-up counter restarts whenever the block is fully released
  always @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      DELAY_POWER <= 1'b0;
      DELAY_READY <= 1'b0;
      warm_q <= 9'h000;
    end else begin
      DELAY_POWER <= any_pu;
      if (!any_pu) begin
        DELAY_READY <= 1'b0;
        warm_q <= 9'h000;
      end else if (!DELAY_READY) begin
        if (warm_q == WARM_CYC - 9'h001) begin
          DELAY_READY <= 1'b1;
        end else begin
          warm_q <= warm_q + 9'h001;
        end
      end
    end
  end

  // immediate-load selects live in the load control register
  always @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      imm_q <= 4'h0;
    end else if (ld_wr && ws_q[1]) begin
      imm_q <= wd_q[`LDCTL_IMM_LSB +: 4];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // per-submodule control

  genvar g;
  generate
    for (g = 0; g < `SUB_N; g = g + 1) begin : sub
      wire [9:0] idx;
      wire pu_wr;
      wire en_wr;
      wire live;
      wire [4:0] rise_in;
      wire [4:0] fall_in;

      // genvar arithmetic is 32 bits wide; only the word index bits are kept
      localparam [31:0] IDX_FULL = `FRC_IDX_BASE + (`FRC_IDX_STRIDE * g);

      assign idx = IDX_FULL[9:0];
      assign wr_hit[g] = (wa_q[11:2] == idx) && (wa_q[1:0] == 2'h0);
      assign rd_hit[g] = (S_AXI_ARADDR[11:2] == idx) && (S_AXI_ARADDR[1:0] == 2'h0);
      assign pu_wr = wr_go && wr_hit[g] && ws_q[1];
      // the buffered enable is frozen while load_okay is pending
      assign en_wr = wr_go && wr_hit[g] && ws_q[0] && !LOAD_OKAY[g];
      assign rise_in = RISE_FRAC_IN[`FRAC_W*g +: `FRAC_W];
      assign fall_in = FALL_FRAC_IN[`FRAC_W*g +: `FRAC_W];
      // fractions only once warmed up, cleared, powered here and enabled
      assign live = DELAY_READY && clr_q[g] && pu_q[g] && act_q[g];

      // power-up bit is not buffered; takes effect at the write
      always @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
          pu_q[g] <= 1'b0;
        end else if (pu_wr) begin
          pu_q[g] <= wd_q[`FRC_PU_BIT];
        end
      end

      // load_okay: hardware clears at the load cycle, a set in the same cycle wins
      always @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
          LOAD_OKAY[g] <= 1'b0;
        end else if (ld_wr && ws_q[0] && wd_q[`LDCTL_OKAY_LSB + g]) begin
          LOAD_OKAY[g] <= 1'b1;
        end else if (LOAD_CYCLE[g]) begin
          LOAD_OKAY[g] <= 1'b0;
        end
      end

      // buffer written by software, active copy loaded at a pwm load cycle with load_okay set, or every cycle when immediate is set
      always @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
          buf_q[g] <= 1'b0;
          act_q[g] <= 1'b0;
        end else begin
          if (en_wr) begin
            buf_q[g] <= wd_q[`FRC_EN2_BIT];
          end
          if (imm_q[g] || (LOAD_OKAY[g] && LOAD_CYCLE[g])) begin
            act_q[g] <= buf_q[g];
          end
        end
      end

      // analog state counts as cleared after one nonzero-duty period;
      // the output enables play no part, so a dark run also clears it
      always @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
          clr_q[g] <= 1'b0;
        end else if (!any_pu) begin
          clr_q[g] <= 1'b0;
        end else if (DELAY_READY && PERIOD_END[g] && DUTY_NONZERO[g]) begin
          clr_q[g] <= 1'b1;
        end
      end

      // edge fractions to the generator, zero means whole-cycle placement
      always @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
          FRAC_ACTIVE[g] <= 1'b0;
          RISE_FRAC_OUT[`FRAC_W*g +: `FRAC_W] <= 5'h00;
          FALL_FRAC_OUT[`FRAC_W*g +: `FRAC_W] <= 5'h00;
        end else begin
          FRAC_ACTIVE[g] <= live;
          RISE_FRAC_OUT[`FRAC_W*g +: `FRAC_W] <= live ? rise_in : 5'h00;
          FALL_FRAC_OUT[`FRAC_W*g +: `FRAC_W] <= live ? fall_in : 5'h00;
        end
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // read path

  reg [15:0] rd_word;
  reg rd_ok;
  integer k;

  // reserved bits stay zero by building the word field by field;
  // the test bit mirrors the cleared analog state of that submodule
  always @* begin
    rd_word = 16'h0000;
    rd_ok = 1'b0;
    for (k = 0; k < `SUB_N; k = k + 1) begin
      if (rd_hit[k]) begin
        rd_ok = 1'b1;
        rd_word[`FRC_TEST_BIT] = clr_q[k];
        rd_word[`FRC_PU_BIT] = pu_q[k];
        rd_word[`FRC_EN2_BIT] = buf_q[k];
      end
    end
    if (S_AXI_ARADDR == `LDCTL_ADDR) begin
      rd_ok = 1'b1;
      rd_word[`LDCTL_OKAY_LSB +: 4] = LOAD_OKAY;
      rd_word[`LDCTL_IMM_LSB +: 4] = imm_q;
    end
    if (S_AXI_ARADDR == `STAT_ADDR) begin
      rd_ok = 1'b1;
      rd_word[`STAT_POWER_BIT] = DELAY_POWER;
      rd_word[`STAT_READY_BIT] = DELAY_READY;
      rd_word[`STAT_CLR_LSB +: 4] = clr_q;
      rd_word[`STAT_ACT_LSB +: 4] = act_q;
    end
  end

  // read answer registered on the same edge that takes the address
  always @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      S_AXI_ARREADY <= 1'b1;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h00000000;
      S_AXI_RRESP <= `RESP_OKAY;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA <= {16'h0000, rd_word};
      S_AXI_RRESP <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
    end else if (S_AXI_RVALID && S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_ARREADY <= 1'b1;
    end
  end

endmodule // frac_ctrl

`default_nettype wire

// ---- frac_ctrl_props.sv ----
// assertion checker for frac_ctrl, watching its ports only
// assumes one clock domain; bound into frac_ctrl at the foot
`timescale 1ns/1ps
`default_nettype none
module frac_ctrl_props (
  // clock, reset and bus handshakes
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  input wire logic S_AXI_WVALID,
  input wire logic S_AXI_WREADY,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  // pwm side
  input wire logic [3:0] LOAD_CYCLE,
  input wire logic [3:0] LOAD_OKAY,
  input wire logic DELAY_POWER,
  input wire logic DELAY_READY,
  input wire logic [3:0] FRAC_ACTIVE,
  input wire logic [19:0] RISE_FRAC_IN,
  input wire logic [19:0] FALL_FRAC_IN,
  input wire logic [19:0] RISE_FRAC_OUT,
  input wire logic [19:0] FALL_FRAC_OUT
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  ////////////////////////////////////////
  // powered cycles, saturating so a long run cannot wrap it
  logic [8:0] pwr_cnt_q;
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) pwr_cnt_q <= 9'h000;
    else if (!DELAY_POWER) pwr_cnt_q <= 9'h000;
    else if (pwr_cnt_q != 9'h1FF) pwr_cnt_q <= pwr_cnt_q + 9'h001;
  end
  // a write lands here and may set load_okay again, so it is excluded
  wire wr_apply = !S_AXI_AWREADY && !S_AXI_WREADY && !S_AXI_BVALID;
  wire [19:0] act_mask = {{5{FRAC_ACTIVE[3]}}, {5{FRAC_ACTIVE[2]}},
    {5{FRAC_ACTIVE[1]}}, {5{FRAC_ACTIVE[0]}}};
  sequence s_wr_both;
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
  endsequence
  property p_ready_late;
    DELAY_READY |-> pwr_cnt_q >= 9'h0F9;
  endproperty
  a_ready_late: assert property (p_ready_late) else $error("warm-up too short");
  property p_ready_time;
    DELAY_POWER && pwr_cnt_q == 9'h0F9 |-> DELAY_READY;
  endproperty
  a_ready_time: assert property (p_ready_time) else $error("warm-up too long");
  property p_off_quiet;
    !DELAY_POWER |-> !DELAY_READY && FRAC_ACTIVE == 4'h0;
  endproperty
  a_off_quiet: assert property (p_off_quiet) else $error("active while off");
  property p_act_ready;
    FRAC_ACTIVE != 4'h0 |-> $past(DELAY_READY);
  endproperty
  a_act_ready: assert property (p_act_ready) else $error("active before ready");
  property p_rise;
    RISE_FRAC_OUT == ($past(RISE_FRAC_IN) & act_mask);
  endproperty
  a_rise: assert property (p_rise) else $error("rise fraction wrong");
  property p_fall;
    FALL_FRAC_OUT == ($past(FALL_FRAC_IN) & act_mask);
  endproperty
  a_fall: assert property (p_fall) else $error("fall fraction wrong");
  property p_load_clr;
    (LOAD_CYCLE & LOAD_OKAY) != 4'h0 && !wr_apply |=> (LOAD_OKAY & $past(LOAD_CYCLE)) == 4'h0;
  endproperty
  a_load_clr: assert property (p_load_clr) else $error("load_okay kept");
  property p_wr_walk;
    s_wr_both |=> !S_AXI_AWREADY && !S_AXI_WREADY ##1 S_AXI_BVALID;
  endproperty
  a_wr_walk: assert property (p_wr_walk) else $error("write walk broken");
  property p_b_done;
    S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID && S_AXI_AWREADY && S_AXI_WREADY;
  endproperty
  a_b_done: assert property (p_b_done) else $error("write end broken");
endmodule // frac_ctrl_props
bind frac_ctrl frac_ctrl_props i_props (
  .CLK_SYS(CLK_SYS),
  .RST_N(RST_N),
  .S_AXI_AWVALID(S_AXI_AWVALID),
  .S_AXI_AWREADY(S_AXI_AWREADY),
  .S_AXI_WVALID(S_AXI_WVALID),
  .S_AXI_WREADY(S_AXI_WREADY),
  .S_AXI_BVALID(S_AXI_BVALID),
  .S_AXI_BREADY(S_AXI_BREADY),
  .LOAD_CYCLE(LOAD_CYCLE),
  .LOAD_OKAY(LOAD_OKAY),
  .DELAY_POWER(DELAY_POWER),
  .DELAY_READY(DELAY_READY),
  .FRAC_ACTIVE(FRAC_ACTIVE),
  .RISE_FRAC_IN(RISE_FRAC_IN),
  .FALL_FRAC_IN(FALL_FRAC_IN),
  .RISE_FRAC_OUT(RISE_FRAC_OUT),
  .FALL_FRAC_OUT(FALL_FRAC_OUT)
);
`default_nettype wire

// ---- frac_ctrl_regs.vh ----
// register map, field positions, reset values and timing figures
// for the fractional control block; definitions only
`ifndef FRAC_CTRL_REGS_VH
`define FRAC_CTRL_REGS_VH

// bus geometry
`define ADDR_W 12
`define SUB_N 4
// word index of the first fraction_control and the per-submodule stride
`define FRC_IDX_BASE 10'h010
`define FRC_IDX_STRIDE 10'h030
// block-wide registers, byte addresses
`define LDCTL_ADDR 12'h300
`define STAT_ADDR 12'h304

// fraction_control fields
`define FRC_TEST_BIT 15
`define FRC_PU_BIT 8
`define FRC_EN2_BIT 4
`define FRC_RESET 16'h0000

// load control fields
`define LDCTL_OKAY_LSB 0
`define LDCTL_IMM_LSB 8

// status fields
`define STAT_POWER_BIT 0
`define STAT_READY_BIT 1
`define STAT_CLR_LSB 4
`define STAT_ACT_LSB 8

// fraction value width per edge
`define FRAC_W 5

// answers
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// timing
`define WARM_UP_NS 25000
`define CLK_PERIOD_NS 100

`endif

// ---- frac_ctrl_test.sv ----
// self-checking bench for frac_ctrl, registers over axi4-lite
// assumes the checker is bound in; clock 10 MHz
`timescale 1ns/1ps
`default_nettype none
module frac_ctrl_test;
  logic clk_sys = 1'h0, rst_n = 1'h0;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] load_cycle = 4'h0, period_end = 4'h0, duty_nz = 4'hF, load_okay, fact;
  logic [19:0] rise_in = 20'hA5C3E, fall_in = 20'h1B7D2, rise_out, fall_out;
  logic awready, wready, bvalid, arready, rvalid, dpow, drdy;
  logic [1:0] bresp, rresp;
  integer bad_count = 0, tests_run = 0, cyc = 0;
  frac_ctrl i_dut (.CLK_SYS(clk_sys), .RST_N(rst_n),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .LOAD_CYCLE(load_cycle), .PERIOD_END(period_end), .DUTY_NONZERO(duty_nz),
    .RISE_FRAC_IN(rise_in), .FALL_FRAC_IN(fall_in), .DELAY_POWER(dpow), .DELAY_READY(drdy),
    .LOAD_OKAY(load_okay), .FRAC_ACTIVE(fact), .RISE_FRAC_OUT(rise_out), .FALL_FRAC_OUT(fall_out));
  // warm-up count and fractional use both assume the bus clock the design counts in
  always #50 clk_sys = ~clk_sys;
  ////////////////////////////////////////
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // the run needs well under a thousand cycles
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      bad_count++;
      tally_and_finish;
    end
  end
  task automatic chk(input logic ok, input string m);
    tests_run++;
    if (ok !== 1'h1) begin
      bad_count++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  task automatic tk(input integer n);
    repeat (n) @(posedge clk_sys);
  endtask
  function automatic logic [11:0] fa(input integer i);
    fa = 12'h040 + 12'h0C0 * i[11:0];
  endfunction
  // address and data offered together; bready held until bvalid
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge clk_sys);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge clk_sys);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (awvalid || wvalid);
    while (!bvalid) @(posedge clk_sys);
    bready <= 1'h0;
    chk(bresp === r, "write response");
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] r);
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do @(posedge clk_sys); while (!arready);
    arvalid <= 1'h0;
    while (!rvalid) @(posedge clk_sys);
    rready <= 1'h0;
    chk(rdata === e && rresp === r, "read data");
  endtask
  task automatic pulse(input logic [3:0] ld, input logic [3:0] pe);
    @(posedge clk_sys);
    load_cycle <= ld;
    period_end <= pe;
    @(posedge clk_sys);
    load_cycle <= 4'h0;
    period_end <= 4'h0;
    tk(2);
  endtask
  ////////////////////////////////////////
  task automatic t_reset;
    for (int i = 0; i < 4; i++) rd(fa(i), 32'h0, 2'h0);
    rd(12'h044, 32'h0, 2'h2);
    wr(12'h048, 32'hFFFF, 2'h2);
    chk(dpow === 1'h0 && fact === 4'h0, "idle after reset");
  endtask
  // all ones written: only power-up and enable may stick
  task automatic t_warm;
    for (int i = 0; i < 4; i++) wr(fa(i), 32'hFFFF, 2'h0);
    for (int i = 0; i < 4; i++) rd(fa(i), 32'h0110, 2'h0);
    chk(dpow === 1'h1 && drdy === 1'h0, "warm-up");
    tk(240);
    chk(drdy === 1'h1, "not ready");
    // a period with zero duty must not count as clearing the analog state
    duty_nz <= 4'h0;
    pulse(4'h0, 4'hF);
    duty_nz <= 4'hF;
    rd(fa(0), 32'h0110, 2'h0);
  endtask
  task automatic t_clear;
    wr(12'h300, 32'h1, 2'h0);
    wr(fa(0), 32'h0100, 2'h0);
    rd(fa(0), 32'h0110, 2'h0);
    pulse(4'h1, 4'h1);
    chk(load_okay === 4'h0 && fact === 4'h1, "load");
    chk(rise_out === {15'h0, rise_in[4:0]} && fall_out === {15'h0, fall_in[4:0]}, "frac");
    rd(fa(0), 32'h8110, 2'h0);
    wr(12'h300, 32'h0200, 2'h0);
    pulse(4'h0, 4'h6);
    chk(fact === 4'h3, "immediate");
    rd(12'h300, 32'h0200, 2'h0);
    rd(12'h304, 32'h0373, 2'h0);
  endtask
  task automatic t_down;
    for (int i = 0; i < 4; i++) if (i != 1) wr(fa(i), 32'h0, 2'h0);
    tk(2);
    chk(dpow === 1'h1 && fact === 4'h2, "early down");
    wr(fa(1), 32'h0, 2'h0);
    tk(2);
    chk(dpow === 1'h0 && drdy === 1'h0 && fact === 4'h0, "still on");
    chk(rise_out === 20'h0 && fall_out === 20'h0, "whole cycle");
    rd(fa(0), 32'h0, 2'h0);
  endtask
  initial begin
    tk(2);
    rst_n <= 1'h1;
    t_reset;
    t_warm;
    t_clear;
    t_down;
    tally_and_finish;
  end
endmodule // frac_ctrl_test
`default_nettype wire
